// File: include/read_port_if.sv
// Read request and registered answer of one register read port
`timescale 1ns/100ps
interface read_port_if;
  import regfile_pkg::*;
  logic [2:0]  sel;
  size_type    size;
  logic [31:0] data;
  modport client (output sel, output size, input data);
  modport server (input sel, input size, output data);
endinterface

// File: include/regfile_pkg.sv
// Constants, types and view helpers of the register file
package regfile_pkg;

  localparam int GPR_WIDTH = 32;
  localparam int NUM_GPR   = 8;
  localparam int SEG_WIDTH = 16;
  localparam int NUM_SEG   = 6;
  localparam int HALF_W    = 16;
  localparam int BYTE_W    = 8;
  localparam int HIGH_SEL_BIT = 2;

  // General-purpose register indices
  localparam logic [2:0] IDX_ACCUM  = 3'h0;
  localparam logic [2:0] IDX_COUNT  = 3'h1;
  localparam logic [2:0] IDX_IO     = 3'h2;
  localparam logic [2:0] IDX_BASE   = 3'h3;
  localparam logic [2:0] IDX_STACK  = 3'h4;
  localparam logic [2:0] IDX_FRAME  = 3'h5;
  localparam logic [2:0] IDX_SOURCE = 3'h6;
  localparam logic [2:0] IDX_DEST   = 3'h7;

  // Segment selector indices; codes 6 and 7 are illegal
  localparam logic [2:0] SEG_EXTRA  = 3'h0;
  localparam logic [2:0] SEG_CODE   = 3'h1;
  localparam logic [2:0] SEG_STACK  = 3'h2;
  localparam logic [2:0] SEG_DATA   = 3'h3;
  localparam logic [2:0] SEG_THIRD  = 3'h4;
  localparam logic [2:0] SEG_FOURTH = 3'h5;

  localparam logic [31:0] GPR_RESET = 32'h0000_0000;
  localparam logic [15:0] SEG_RESET = 16'h0000;
  localparam logic [31:0] IP_RESET  = 32'h0000_0000;

  localparam logic [31:0] STEP_BYTE  = 32'h0000_0001;
  localparam logic [31:0] STEP_WORD  = 32'h0000_0002;
  localparam logic [31:0] STEP_DWORD = 32'h0000_0004;

  typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_DWORD} size_type;
  typedef logic [NUM_GPR-1:0][GPR_WIDTH-1:0] gpr_file_type;
  typedef logic [NUM_SEG-1:0][SEG_WIDTH-1:0] seg_file_type;

  // Byte selects 4..7 name the high byte of registers 0..3
  function automatic logic [2:0] view_target(logic [2:0] sel,
                                             size_type size);
    view_target = (size == SZ_BYTE) ? {1'b0, sel[1:0]} : sel;
  endfunction

  function automatic logic [31:0] view_read(gpr_file_type regs,
                                            logic [2:0] sel,
                                            size_type size);
    logic [31:0] w;
    w = regs[view_target(sel, size)];
    unique case (size)
      SZ_BYTE: begin
        if (sel[HIGH_SEL_BIT]) begin
          view_read = {24'h00_0000, w[HALF_W-1:BYTE_W]};
        end else begin
          view_read = {24'h00_0000, w[BYTE_W-1:0]};
        end
      end
      SZ_WORD:  view_read = {16'h0000, w[HALF_W-1:0]};
      SZ_DWORD: view_read = w;
      default:  view_read = w;
    endcase
  endfunction

  function automatic logic [31:0] view_merge(logic [31:0] old,
                                             logic [31:0] data,
                                             logic [2:0] sel,
                                             size_type size);
    unique case (size)
      SZ_BYTE: begin
        if (sel[HIGH_SEL_BIT]) begin
          view_merge = {old[GPR_WIDTH-1:HALF_W], data[BYTE_W-1:0],
                        old[BYTE_W-1:0]};
        end else begin
          view_merge = {old[GPR_WIDTH-1:BYTE_W], data[BYTE_W-1:0]};
        end
      end
      SZ_WORD:  view_merge = {old[GPR_WIDTH-1:HALF_W], data[HALF_W-1:0]};
      SZ_DWORD: view_merge = data;
      default:  view_merge = old;
    endcase
  endfunction

endpackage

// File: src/gpr_and_segment_reg_file.sv
// General-purpose and segment selector register file of the core
//
// Summary of operation
// - Eight 32-bit general-purpose registers.
// - Word view selects bits 15 to 0.
// - First four registers expose high and low bytes.
// - String operands come implicitly from fixed registers.
// - Count register counts string and loop iterations.
// - Accumulator implicitly holds operands and results.
// - Data-base pointer defaults to first data segment.
// - Source uses data segment, destination extra segment.
// - Stack and frame pointers use stack segment.
// - Six 16-bit segment selector registers.
// - Fetch address is code selector plus offset.
// - Code selector changes only by control transfer.
// - Stack operations use the stack selector.
// - Stack selector is explicitly loadable.
// - Four data selectors are explicitly loadable.
// - Instruction offset holds next instruction offset.
`timescale 1ns/100ps
module gpr_and_segment_reg_file #(
  parameter int INSTR_LEN_W = 4
) (
  input  wire logic                 clk_i,
  input  wire logic                 nrst_i,
  // Explicit register write
  input  wire logic                 wr_en_i,
  input  wire logic [2:0]           wr_sel_i,
  input  regfile_pkg::size_type     wr_size_i,
  input  wire logic [31:0]          wr_data_i,
  // Two read ports, answer one cycle later
  input  wire logic [2:0]           rd_a_sel_i,
  input  regfile_pkg::size_type     rd_a_size_i,
  output logic [31:0]               rd_a_data_o,
  input  wire logic [2:0]           rd_b_sel_i,
  input  regfile_pkg::size_type     rd_b_size_i,
  output logic [31:0]               rd_b_data_o,
  // Implicit accumulator result
  input  wire logic                 acc_wr_i,
  input  wire logic [31:0]          acc_data_i,
  output logic [31:0]               accum_o,
  // Implicit counting and string stepping
  input  wire logic                 cnt_dec_i,
  output logic [31:0]               count_o,
  output logic                      count_zero_o,
  input  wire logic                 str_step_i,
  input  wire logic                 str_dir_i,
  input  regfile_pkg::size_type     str_size_i,
  output logic [15:0]               str_src_sel_o,
  output logic [31:0]               str_src_off_o,
  output logic [15:0]               str_dst_sel_o,
  output logic [31:0]               str_dst_off_o,
  // Stack addressing
  output logic [15:0]               stack_sel_o,
  output logic [31:0]               stack_ptr_o,
  // Pointer register with its default segment
  input  wire logic [2:0]           ptr_sel_i,
  output logic [15:0]               ptr_seg_o,
  output logic [31:0]               ptr_off_o,
  // Explicit selector load and selector read
  input  wire logic                 seg_wr_en_i,
  input  wire logic [2:0]           seg_wr_sel_i,
  input  wire logic [15:0]          seg_wr_data_i,
  output logic                      seg_refused_o,
  input  wire logic [2:0]           seg_rd_sel_i,
  output logic [15:0]               seg_rd_data_o,
  // Control transfer and instruction offset
  input  wire logic                 xfer_load_i,
  input  wire logic [15:0]          xfer_sel_i,
  input  wire logic [31:0]          xfer_offset_i,
  input  wire logic                 ip_advance_i,
  input  wire logic [INSTR_LEN_W-1:0] ip_len_i,
  output logic [15:0]               fetch_sel_o,
  output logic [31:0]               fetch_offset_o
);
  import regfile_pkg::*;

  if (INSTR_LEN_W < 1 || INSTR_LEN_W > GPR_WIDTH) begin : g_len_check
    $error("INSTR_LEN_W must lie between 1 and 32");
  end

  gpr_file_type gpr;
  gpr_file_type next_gpr;
  seg_file_type seg;
  logic [31:0]  next_instr_offset;
  logic [31:0]  str_step;
  logic [2:0]   wr_target;
  logic         seg_legal;
  logic         seg_explicit_ok;

  // ---------------- General-purpose registers ----------------

  assign wr_target = view_target(wr_sel_i, wr_size_i);

  always_comb begin
    unique case (str_size_i)
      SZ_BYTE:  str_step = STEP_BYTE;
      SZ_WORD:  str_step = STEP_WORD;
      SZ_DWORD: str_step = STEP_DWORD;
      default:  str_step = STEP_BYTE;
    endcase
  end

  // Explicit writes are applied last so they win over implicit updates
  always_comb begin
    next_gpr = gpr;
    if (cnt_dec_i) begin
      next_gpr[IDX_COUNT] = gpr[IDX_COUNT] - 32'h0000_0001;
    end
    if (str_step_i) begin
      if (str_dir_i) begin
        next_gpr[IDX_SOURCE] = gpr[IDX_SOURCE] - str_step;
        next_gpr[IDX_DEST]   = gpr[IDX_DEST] - str_step;
      end else begin
        next_gpr[IDX_SOURCE] = gpr[IDX_SOURCE] + str_step;
        next_gpr[IDX_DEST]   = gpr[IDX_DEST] + str_step;
      end
    end
    if (acc_wr_i) begin
      next_gpr[IDX_ACCUM] = acc_data_i;
    end
    if (wr_en_i) begin
      next_gpr[wr_target] = view_merge(gpr[wr_target], wr_data_i,
                                       wr_sel_i, wr_size_i);
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      gpr <= {NUM_GPR{GPR_RESET}};
    end else begin
      gpr <= next_gpr;
    end
  end

  // Registered so the loop test does not lengthen the decode path
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      count_zero_o <= (GPR_RESET == 32'h0000_0000);
    end else begin
      count_zero_o <= (next_gpr[IDX_COUNT] == 32'h0000_0000);
    end
  end

  read_port_if rd_a ();
  read_port_if rd_b ();

  assign rd_a.sel    = rd_a_sel_i;
  assign rd_a.size   = rd_a_size_i;
  assign rd_b.sel    = rd_b_sel_i;
  assign rd_b.size   = rd_b_size_i;
  assign rd_a_data_o = rd_a.data;
  assign rd_b_data_o = rd_b.data;

  gpr_read_port u_read_a (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .regs_i (gpr),
    .port   (rd_a.server)
  );

  gpr_read_port u_read_b (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .regs_i (gpr),
    .port   (rd_b.server)
  );

  // ---------------- Segment selectors ----------------

  assign seg_legal = (seg_wr_sel_i <= SEG_FOURTH);
  // Code selector is never an explicit load target
  assign seg_explicit_ok = seg_wr_en_i && seg_legal &&
                           (seg_wr_sel_i != SEG_CODE);

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      seg <= {NUM_SEG{SEG_RESET}};
    end else begin
      if (seg_explicit_ok) begin
        seg[seg_wr_sel_i] <= seg_wr_data_i;
      end
      if (xfer_load_i) begin
        seg[SEG_CODE] <= xfer_sel_i;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      seg_refused_o <= 1'b0;
    end else begin
      seg_refused_o <= seg_wr_en_i && !seg_explicit_ok;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      seg_rd_data_o <= SEG_RESET;
    end else if (seg_rd_sel_i <= SEG_FOURTH) begin
      seg_rd_data_o <= seg[seg_rd_sel_i];
    end else begin
      seg_rd_data_o <= 16'h0000;
    end
  end

  // ---------------- Instruction offset ----------------

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      next_instr_offset <= IP_RESET;
    end else if (xfer_load_i) begin
      next_instr_offset <= xfer_offset_i;
    end else if (ip_advance_i) begin
      next_instr_offset <= next_instr_offset +
                           GPR_WIDTH'(ip_len_i);
    end
  end

  // ---------------- Address pairs ----------------

  assign fetch_sel_o    = seg[SEG_CODE];
  assign fetch_offset_o = next_instr_offset;
  assign stack_sel_o    = seg[SEG_STACK];
  assign stack_ptr_o    = gpr[IDX_STACK];
  assign str_src_sel_o  = seg[SEG_DATA];
  assign str_src_off_o  = gpr[IDX_SOURCE];
  assign str_dst_sel_o  = seg[SEG_EXTRA];
  assign str_dst_off_o  = gpr[IDX_DEST];
  assign count_o        = gpr[IDX_COUNT];
  assign accum_o        = gpr[IDX_ACCUM];

  // Default segment follows the pointer register's role
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ptr_seg_o <= SEG_RESET;
      ptr_off_o <= GPR_RESET;
    end else begin
      ptr_off_o <= gpr[ptr_sel_i];
      unique case (ptr_sel_i)
        IDX_STACK, IDX_FRAME: ptr_seg_o <= seg[SEG_STACK];
        IDX_DEST:             ptr_seg_o <= seg[SEG_EXTRA];
        IDX_BASE:             ptr_seg_o <= seg[SEG_DATA];
        default:              ptr_seg_o <= seg[SEG_DATA];
      endcase
    end
  end

  // ---------------- Checks ----------------

  logic [15:0] io_upper;
  logic [7:0]  accum_low;
  logic [15:0] code_now;
  logic [15:0] data_now;
  logic [15:0] stack_now;
  logic        no_gpr_write;

  assign io_upper     = gpr[IDX_IO][31:16];
  assign accum_low    = gpr[IDX_ACCUM][7:0];
  assign code_now     = seg[SEG_CODE];
  assign data_now     = seg[SEG_DATA];
  assign stack_now    = seg[SEG_STACK];
  assign no_gpr_write = !wr_en_i;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  word_write_keep_a: assert property (
    wr_en_i && wr_size_i == SZ_WORD && wr_sel_i == IDX_IO
    |=> gpr[IDX_IO][31:16] == $past(io_upper) &&
        gpr[IDX_IO][15:0] == $past(wr_data_i[15:0]))
    else $error("word write disturbed upper half");

  high_byte_write_a: assert property (
    wr_en_i && wr_size_i == SZ_BYTE && wr_sel_i == 3'h4 && !acc_wr_i
    |=> accum_o[15:8] == $past(wr_data_i[7:0]) &&
        accum_o[7:0] == $past(accum_low))
    else $error("high byte write wrong");

  code_refused_a: assert property (
    seg_wr_en_i && seg_wr_sel_i == SEG_CODE && !xfer_load_i
    |=> seg_refused_o && fetch_sel_o == $past(code_now))
    else $error("code selector took an explicit load");

  xfer_fetch_a: assert property (
    xfer_load_i |=> fetch_sel_o == $past(xfer_sel_i) &&
                    fetch_offset_o == $past(xfer_offset_i))
    else $error("control transfer not reflected in fetch");

  ip_advance_a: assert property (
    ip_advance_i && !xfer_load_i
    |=> fetch_offset_o == $past(fetch_offset_o) + 32'($past(ip_len_i)))
    else $error("instruction offset did not advance");

  stack_load_a: assert property (
    seg_wr_en_i && seg_wr_sel_i == SEG_STACK
    |=> stack_sel_o == $past(seg_wr_data_i) && !seg_refused_o)
    else $error("stack selector load lost");

  data_load_a: assert property (
    seg_wr_en_i && seg_wr_sel_i == SEG_DATA
    |=> str_src_sel_o == $past(seg_wr_data_i))
    else $error("data selector load lost");

  count_dec_a: assert property (
    cnt_dec_i && no_gpr_write
    |=> count_o == $past(count_o) - 32'h0000_0001 &&
        count_zero_o == (count_o == 32'h0000_0000))
    else $error("count register not decremented");

  string_step_a: assert property (
    str_step_i && !str_dir_i && str_size_i == SZ_DWORD && no_gpr_write
    |=> str_src_off_o == $past(str_src_off_o) + 32'h0000_0004 &&
        str_dst_off_o == $past(str_dst_off_o) + 32'h0000_0004)
    else $error("string pointers did not step by four");

  acc_implicit_a: assert property (
    acc_wr_i && no_gpr_write |=> accum_o == $past(acc_data_i))
    else $error("implicit accumulator result lost");

  base_default_a: assert property (
    ptr_sel_i == IDX_BASE |=> ptr_seg_o == $past(data_now))
    else $error("data-base pointer not in data segment");

  frame_default_a: assert property (
    ptr_sel_i == IDX_FRAME |=> ptr_seg_o == $past(stack_now))
    else $error("frame pointer not in stack segment");

  source_default_a: assert property (
    ptr_sel_i == IDX_SOURCE |=> ptr_seg_o == $past(data_now))
    else $error("source pointer not in data segment");

  dest_default_a: assert property (
    ptr_sel_i == IDX_DEST |=> ptr_seg_o == $past(str_dst_sel_o))
    else $error("destination pointer not in extra segment");

  low_byte_write_a: assert property (
    wr_en_i && wr_size_i == SZ_BYTE && wr_sel_i == IDX_COUNT && !cnt_dec_i
    |=> count_o[31:8] == $past(count_o[31:8]) &&
        count_o[7:0] == $past(wr_data_i[7:0]))
    else $error("low byte write disturbed other bits");

  seg_illegal_read_a: assert property (
    seg_rd_sel_i > SEG_FOURTH |=> seg_rd_data_o == 16'h0000)
    else $error("illegal selector code read nonzero");

  count_to_zero_c: cover property (
    cnt_dec_i && count_o == 32'h0000_0001 ##1 count_zero_o);
  code_refused_c: cover property (seg_refused_o);
  xfer_then_step_c: cover property (xfer_load_i ##[1:2] ip_advance_i);
  string_down_c: cover property (str_step_i && str_dir_i);

endmodule

// File: src/gpr_read_port.sv
// One registered read port with 8, 16 and 32-bit views
`timescale 1ns/100ps
module gpr_read_port (
  input  wire logic                 clk_i,
  input  wire logic                 nrst_i,
  input  regfile_pkg::gpr_file_type regs_i,
  read_port_if.server               port
);
  import regfile_pkg::*;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      port.data <= GPR_RESET;
    end else begin
      port.data <= view_read(regs_i, port.sel, port.size);
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  word_read_zero_a: assert property (
    port.size == SZ_WORD |=> port.data[31:16] == 16'h0000)
    else $error("word view read shows upper bits");

  byte_read_zero_a: assert property (
    port.size == SZ_BYTE |=> port.data[31:8] == 24'h00_0000)
    else $error("byte view read shows upper bits");

endmodule

// File: testbench/decode_model.sv
// Decode-side model that issues requests to the register file
`timescale 1ns/100ps
module decode_model (
  input  wire logic             clk_i,
  output logic                  wr_en_o,
  output logic [2:0]            wr_sel_o,
  output regfile_pkg::size_type wr_size_o,
  output logic [31:0]           wr_data_o,
  output logic [2:0]            rd_sel_o,
  output regfile_pkg::size_type rd_size_o,
  output logic                  acc_wr_o,
  output logic [31:0]           acc_data_o,
  output logic                  cnt_dec_o,
  output logic                  str_step_o,
  output logic                  str_dir_o,
  output regfile_pkg::size_type str_size_o,
  output logic [2:0]            ptr_sel_o,
  output logic                  seg_wr_en_o,
  output logic [2:0]            seg_wr_sel_o,
  output logic [15:0]           seg_wr_data_o,
  output logic [2:0]            seg_rd_sel_o,
  output logic                  xfer_load_o,
  output logic [15:0]           xfer_sel_o,
  output logic [31:0]           xfer_offset_o,
  output logic                  ip_advance_o,
  output logic [3:0]            ip_len_o
);
  import regfile_pkg::*;
  initial begin
    {wr_en_o, wr_sel_o, wr_data_o, rd_sel_o, acc_wr_o, acc_data_o} = '0;
    {cnt_dec_o, str_step_o, str_dir_o, ptr_sel_o, seg_wr_en_o} = '0;
    {seg_wr_sel_o, seg_wr_data_o, seg_rd_sel_o, xfer_load_o} = '0;
    {xfer_sel_o, xfer_offset_o, ip_advance_o, ip_len_o} = '0;
    wr_size_o = SZ_BYTE;
    rd_size_o = SZ_BYTE;
    str_size_o = SZ_BYTE;
  end
  // Released data flips so a stale value never looks valid
  task automatic fin;
    @(negedge clk_i);
    {wr_en_o, acc_wr_o, cnt_dec_o, str_step_o} = '0;
    {seg_wr_en_o, xfer_load_o, ip_advance_o} = '0;
    wr_data_o = ~wr_data_o;
    acc_data_o = ~acc_data_o;
    seg_wr_data_o = ~seg_wr_data_o;
    xfer_offset_o = ~xfer_offset_o;
  endtask
  task automatic wr(logic [2:0] s, size_type z, logic [31:0] d);
    @(negedge clk_i);
    {wr_en_o, wr_sel_o, wr_data_o} = {1'b1, s, d};
    wr_size_o = z;
    fin;
  endtask
  task automatic acc(logic [31:0] d);
    @(negedge clk_i);
    {acc_wr_o, acc_data_o} = {1'b1, d};
    fin;
  endtask
  task automatic step(logic c, logic s, logic d, size_type z);
    @(negedge clk_i);
    {cnt_dec_o, str_step_o, str_dir_o} = {c, s, d};
    str_size_o = z;
    fin;
  endtask
  // Selectors are loaded before any lookup relies on them
  task automatic seg(logic [2:0] s, logic [15:0] d);
    @(negedge clk_i);
    {seg_wr_en_o, seg_wr_sel_o, seg_wr_data_o} = {1'b1, s, d};
    fin;
  endtask
  task automatic xfer(logic [15:0] s, logic [31:0] o);
    @(negedge clk_i);
    {xfer_load_o, xfer_sel_o, xfer_offset_o} = {1'b1, s, o};
    fin;
  endtask
  task automatic adv(logic [3:0] n);
    @(negedge clk_i);
    {ip_advance_o, ip_len_o} = {1'b1, n};
    fin;
  endtask
  task automatic look(logic [2:0] r, size_type z, logic [2:0] p,
                      logic [2:0] q);
    @(negedge clk_i);
    {rd_sel_o, ptr_sel_o, seg_rd_sel_o} = {r, p, q};
    rd_size_o = z;
    @(negedge clk_i);
  endtask
endmodule

// File: testbench/test_gpr_and_segment_reg_file.sv
// Self-checking bench of the register file
`timescale 1ns/100ps
module test_gpr_and_segment_reg_file;
  import regfile_pkg::*;
  logic        clk_i = 1'b0;
  logic        nrst_i = 1'b0;
  int          err_count = 0;
  int          n_tests = 0;
  int          cycles = 0;
  logic [31:0] g [8];
  logic        wr_en_i, acc_wr_i, cnt_dec_i, str_step_i, str_dir_i;
  logic        seg_wr_en_i, xfer_load_i, ip_advance_i;
  logic        count_zero_o, seg_refused_o;
  logic [2:0]  wr_sel_i, rd_a_sel_i, ptr_sel_i, seg_wr_sel_i, seg_rd_sel_i;
  size_type    wr_size_i, rd_a_size_i, str_size_i;
  logic [3:0]  ip_len_i;
  logic [15:0] seg_wr_data_i, xfer_sel_i, str_src_sel_o, str_dst_sel_o;
  logic [15:0] stack_sel_o, ptr_seg_o, seg_rd_data_o, fetch_sel_o;
  logic [31:0] wr_data_i, acc_data_i, xfer_offset_i, rd_a_data_o;
  logic [31:0] rd_b_data_o, accum_o, count_o, str_src_off_o;
  logic [31:0] str_dst_off_o, stack_ptr_o, ptr_off_o, fetch_offset_o;
  logic [2:0]  rd_b_sel_i;
  size_type    rd_b_size_i;
  // Second port reads the mirror register in the same view
  assign rd_b_sel_i = ~rd_a_sel_i;
  assign rd_b_size_i = rd_a_size_i;
  always #25 clk_i = ~clk_i;

  decode_model pm_u (.clk_i, .wr_en_o(wr_en_i), .wr_sel_o(wr_sel_i),
    .wr_size_o(wr_size_i), .wr_data_o(wr_data_i), .rd_sel_o(rd_a_sel_i),
    .rd_size_o(rd_a_size_i), .acc_wr_o(acc_wr_i), .acc_data_o(acc_data_i),
    .cnt_dec_o(cnt_dec_i), .str_step_o(str_step_i), .str_dir_o(str_dir_i),
    .str_size_o(str_size_i), .ptr_sel_o(ptr_sel_i),
    .seg_wr_en_o(seg_wr_en_i), .seg_wr_sel_o(seg_wr_sel_i),
    .seg_wr_data_o(seg_wr_data_i), .seg_rd_sel_o(seg_rd_sel_i),
    .xfer_load_o(xfer_load_i), .xfer_sel_o(xfer_sel_i),
    .xfer_offset_o(xfer_offset_i), .ip_advance_o(ip_advance_i),
    .ip_len_o(ip_len_i));

  gpr_and_segment_reg_file #(.INSTR_LEN_W(4)) dut_u (.clk_i, .nrst_i,
    .wr_en_i, .wr_sel_i, .wr_size_i, .wr_data_i, .rd_a_sel_i, .rd_a_size_i,
    .rd_a_data_o, .rd_b_sel_i, .rd_b_size_i, .rd_b_data_o, .acc_wr_i,
    .acc_data_i, .accum_o, .cnt_dec_i, .count_o, .count_zero_o,
    .str_step_i, .str_dir_i, .str_size_i, .str_src_sel_o, .str_src_off_o,
    .str_dst_sel_o, .str_dst_off_o, .stack_sel_o, .stack_ptr_o, .ptr_sel_i,
    .ptr_seg_o, .ptr_off_o, .seg_wr_en_i, .seg_wr_sel_i, .seg_wr_data_i,
    .seg_refused_o, .seg_rd_sel_i, .seg_rd_data_o, .xfer_load_i,
    .xfer_sel_i, .xfer_offset_i, .ip_advance_i, .ip_len_i, .fetch_sel_o,
    .fetch_offset_o);

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      $display("BAD timeout expected done seen hang");
      end_sim;
    end
  end
  // Mirror of the register contents, merged by hand
  task automatic wr(logic [2:0] s, size_type z, logic [31:0] d);
    logic [2:0] t;
    t = (z == SZ_BYTE) ? {1'b0, s[1:0]} : s;
    pm_u.wr(s, z, d);
    if (z == SZ_DWORD) g[t] = d;
    else if (z == SZ_WORD) g[t][15:0] = d[15:0];
    else if (z == SZ_BYTE && s[2]) g[t][15:8] = d[7:0];
    else if (z == SZ_BYTE) g[t][7:0] = d[7:0];
  endtask
  function automatic logic [31:0] view(logic [2:0] s, size_type z);
    logic [31:0] w;
    w = g[(z == SZ_BYTE) ? {1'b0, s[1:0]} : s];
    if (z == SZ_BYTE) w = s[2] ? {24'h0, w[15:8]} : {24'h0, w[7:0]};
    else if (z == SZ_WORD) w = {16'h0, w[15:0]};
    return w;
  endfunction
  task automatic all_views;
    logic [2:0] s;
    size_type   z;
    for (int i = 0; i < 24; i++) begin
      s = i[2:0];
      z = size_type'(2'(i / 8));
      pm_u.look(s, z, 3'h0, 3'h0);
      chk("rd_a view", rd_a_data_o, view(s, z));
      chk("rd_b view", rd_b_data_o, view(~s, z));
    end
  endtask

  task automatic t_reset;
    for (int i = 0; i < 8; i++) g[i] = 32'h0;
    chk("count_zero", {31'h0, count_zero_o}, 32'h1);
    chk("fetch_offset", fetch_offset_o, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_gpr;
    for (int i = 0; i < 8; i++) wr(i[2:0], SZ_DWORD, 32'h9182_A3B4 + i);
    all_views;
    wr(3'h4, SZ_BYTE, 32'hFFFF_FFAB);
    wr(3'h1, SZ_BYTE, 32'hFFFF_FFCD);
    wr(3'h5, SZ_WORD, 32'hFFFF_BEEF);
    wr(3'h2, SZ_WORD, 32'hFFFF_5A5A);
    wr(3'h7, SZ_BYTE, 32'h0000_0012);
    pm_u.wr(3'h2, size_type'(2'h3), 32'h0); // refused size keeps value
    all_views;
    chk("accum", accum_o, g[0]);
    $display("register view test done");
  endtask
  task automatic t_implicit;
    pm_u.acc(32'h89AB_CDEF);
    g[0] = 32'h89AB_CDEF;
    chk("accum implicit", accum_o, g[0]);
    wr(3'h1, SZ_DWORD, 32'h1);
    pm_u.step(1'b1, 1'b0, 1'b0, SZ_BYTE);
    chk("count", count_o, 32'h0);
    chk("count_zero", {31'h0, count_zero_o}, 32'h1);
    pm_u.step(1'b1, 1'b0, 1'b0, SZ_BYTE);
    chk("count wrap", count_o, 32'hFFFF_FFFF);
    chk("count_zero", {31'h0, count_zero_o}, 32'h0);
    wr(3'h6, SZ_DWORD, 32'h1000);
    wr(3'h7, SZ_DWORD, 32'h2000);
    pm_u.step(1'b0, 1'b1, 1'b0, SZ_WORD);
    chk("src up", str_src_off_o, 32'h1002);
    chk("dst up", str_dst_off_o, 32'h2002);
    pm_u.step(1'b1, 1'b1, 1'b1, SZ_DWORD);
    chk("src down", str_src_off_o, 32'h0FFE);
    chk("dst down", str_dst_off_o, 32'h1FFE);
    chk("count loop", count_o, 32'hFFFF_FFFE);
    pm_u.step(1'b0, 1'b1, 1'b0, SZ_DWORD);
    chk("src up4", str_src_off_o, 32'h1002);
    chk("dst up4", str_dst_off_o, 32'h2002);
    pm_u.step(1'b0, 1'b1, 1'b1, SZ_BYTE);
    chk("src down1", str_src_off_o, 32'h1001);
    chk("dst down1", str_dst_off_o, 32'h2001);
    chk("count kept", count_o, 32'hFFFF_FFFE);
    g[1] = 32'hFFFF_FFFE;
    g[6] = 32'h1001;
    g[7] = 32'h2001;
    wr(3'h4, SZ_DWORD, 32'h0000_8000);
    chk("stack ptr", stack_ptr_o, 32'h0000_8000);
    $display("implicit role test done");
  endtask
  task automatic t_segs;
    logic        bad;
    logic [15:0] e;
    for (int k = 0; k < 8; k++) begin
      bad = (k == 1 || k > 5);
      pm_u.seg(k[2:0], 16'hA000 + 16'(k));
      chk("seg refused", {31'h0, seg_refused_o}, {31'h0, bad});
    end
    chk("code sel", {16'h0, fetch_sel_o}, 32'h0);
    chk("stack sel", {16'h0, stack_sel_o}, 32'hA002);
    chk("src sel", {16'h0, str_src_sel_o}, 32'hA003);
    chk("dst sel", {16'h0, str_dst_sel_o}, 32'hA000);
    for (int k = 0; k < 8; k++) begin
      e = (k == 1 || k > 5) ? 16'h0 : 16'hA000 + 16'(k);
      pm_u.look(3'h0, SZ_DWORD, k[2:0], k[2:0]);
      chk("seg read", {16'h0, seg_rd_data_o}, {16'h0, e});
      e = (k == 4 || k == 5) ? 16'hA002 : (k == 7) ? 16'hA000 : 16'hA003;
      chk("ptr seg", {16'h0, ptr_seg_o}, {16'h0, e});
      chk("ptr off", ptr_off_o, g[k]);
    end
    pm_u.seg(3'h2, 16'h5A5A);
    chk("stack switch", {16'h0, stack_sel_o}, 32'h5A5A);
    $display("segment selector test done");
  endtask
  task automatic t_fetch;
    pm_u.xfer(16'h1234, 32'hFFFF_FFF0);
    chk("fetch sel", {16'h0, fetch_sel_o}, 32'h1234);
    chk("fetch off", fetch_offset_o, 32'hFFFF_FFF0);
    pm_u.adv(4'hF);
    chk("ip step", fetch_offset_o, 32'hFFFF_FFFF);
    pm_u.adv(4'h1);
    chk("ip wrap", fetch_offset_o, 32'h0);
    pm_u.seg(3'h1, 16'h7777);
    chk("code kept", {16'h0, fetch_sel_o}, 32'h1234);
    $display("fetch test done");
  endtask

  initial begin
    repeat (4) @(negedge clk_i);
    nrst_i = 1'b1;
    t_reset;
    t_gpr;
    t_implicit;
    t_segs;
    t_fetch;
    end_sim;
  end
endmodule
